//--- hdl/clock_ctrl_pkg.sv
/*
 Constants, states and field layout of the clock synthesizer control block.
 Assumes one system clock domain plus the free-running bus clock domain.
*/
// Summary of operation
// - Mode strap low: dual pins are active-low stop inputs; high: clock outputs.
// - A clock runs whenever its stop input allows; there is no serial enable.
// - Stopped clocks sit low; last high phase before stopping keeps full width.
// - Start/stop waits free bus clock rise, then affected clock fall.
// - CPU stop low forces CPU/AGP low; PCI stop low forces PCI low.
// - Serial slave only; master can read back held control bytes.
// - Defaults load at power-up; device runs with no serial access.
// - Data changes with clock low; start/stop are data edges with clock high.
// - Write: start, address byte 1101 0010, command, count, then data bytes.
// - Device acknowledges each good byte by pulling data low.
// - Command and count bytes are ignored but acknowledged.
// - After header, the first written byte fills register zero; later bytes are acked and dropped.
// - Read: address with R/W 1, registers returned from zero, no header.
// - Control defaults load only at true power-up.
// - Byte 0 bit 7: spread amount, 0 wide, 1 narrow; default 0.
// - Byte 0 bit 3 picks strap or software code in bits 6..4.
// - Byte 0 bit 2: 0 center spread, 1 down spread.
// - Byte 0 bit 1 enables spread modulation.
// - Byte 0 bit 0 tristates every clock output.
// - Three-bit code selects CPU, PCI and AGP frequency set.
// - Three frequency straps latched at power-up form the hardware code.
// - Mode strap latched at power-up, pulled high; pin then drives its clock.
`default_nettype none
package clock_ctrl_pkg;
   localparam logic [6:0] SLAVE_ADDR = 7'h69;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] UNIMPL_READ = 8'h00;
   localparam int BIT_SPREAD_NARROW = 7;
   localparam int BIT_CODE_HI = 6;
   localparam int BIT_CODE_LO = 4;
   localparam int BIT_SOFT_SELECT = 3;
   localparam int BIT_SPREAD_DOWN = 2;
   localparam int BIT_SPREAD_ENABLE = 1;
   localparam int BIT_TRISTATE = 0;
   localparam logic [3:0] HEADER_BYTES = 4'h2;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] IDX_MAX = 4'hf;
   localparam logic MODE_RESET = 1'b1;
   localparam logic [2:0] STRAP_CODE_RESET = 3'h0;
   localparam logic [1:0] STRAP_SETTLE = 2'h2;
   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_ADDR = 6'h02,
      S_ADDR_ACK = 6'h04,
      S_WRITE = 6'h08,
      S_WRITE_ACK = 6'h10,
      S_READ = 6'h20
   } serial_state_t;
endpackage : clock_ctrl_pkg
`default_nettype wire

//--- hdl/clock_serial_control.sv
/*
 Serial control slave, control byte, straps and clock stop gating of a clock
 synthesizer. Assumes rst is the true power-up reset and the raw clocks come
 from the synthesizer core; pins arrive asynchronous to clock.
*/
`default_nettype none
module clock_serial_control
   import clock_ctrl_pkg::*;
(
   input wire logic clock, // System clock, 25 MHz
   input wire logic rst, // Power-up reset, active high
   input wire logic freeBusClk, // Free-running bus clock, link domain
   input wire logic cpuClkRaw, // Ungated CPU/AGP clock from synthesizer
   input wire logic sdramClkRaw, // SDRAM clock from synthesizer
   input wire logic clk48Raw, // 48 MHz clock from synthesizer
   input wire logic clk24Raw, // 24 MHz clock from synthesizer
   input wire logic serial_clock_pin, // Serial clock pin
   input wire logic serialDataIn, // Serial data pin level
   output logic serialDataOut, // Serial data drive value
   output logic serialDataOe, // Serial data pull-low enable
   input wire logic cpuStopIn, // CPU stop / SDRAM pin level
   output logic cpuStopOut, // SDRAM clock onto that pin
   output logic cpuStopOe, // Pin drive enable
   input wire logic pciStopIn, // PCI stop / SDRAM pin level
   output logic pciStopOut, // SDRAM clock onto that pin
   output logic pciStopOe, // Pin drive enable
   input wire logic strap0PinIn, // 48 MHz / strap bit 0 pin level
   output logic strap0PinOut, // 48 MHz clock
   output logic strap0PinOe, // Pin drive enable
   input wire logic strap1PinIn, // Free bus clock / strap bit 1 pin level
   output logic strap1PinOut, // Free-running bus clock
   output logic strap1PinOe, // Pin drive enable
   input wire logic strap2PinIn, // Bus clock 0 / strap bit 2 pin level
   output logic strap2PinOut, // Gated bus clock
   output logic strap2PinOe, // Pin drive enable
   input wire logic modePinIn, // 24 MHz / mode strap pin level
   output logic modePinOut, // 24 MHz clock
   output logic modePinOe, // Pin drive enable
   output logic cpuClkOut, // Gated CPU/AGP clock
   output logic pciClkOut, // Gated bus clock
   output logic clkOutEnable, // Drive enable of all clock outputs
   output logic [2:0] freqCode, // Effective frequency code
   output logic spreadNarrow, // 1 = narrow spread amount
   output logic spreadDown, // 1 = down spread
   output logic spreadEnable, // 1 = modulation on
   output logic modeStrap // Latched mode strap
);
   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   localparam int NPIN = 8;
   logic [NPIN-1:0] pinRaw;
   logic [NPIN-1:0] pinMeta;
   logic [NPIN-1:0] pinSync;

   assign pinRaw = {serial_clock_pin, serialDataIn, cpuStopIn, pciStopIn,
                    strap0PinIn, strap1PinIn, strap2PinIn, modePinIn};

   genvar g;
   generate
      for (g = 0; g < NPIN; g++) begin : gSync
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               pinMeta[g] <= 1'b1;
               pinSync[g] <= 1'b1;
            end else begin
               pinMeta[g] <= pinRaw[g];
               pinSync[g] <= pinMeta[g];
            end
         end
      end
   endgenerate

   logic sclS;
   logic sdaS;
   logic cpuStopS;
   logic pciStopS;
   assign sclS = pinSync[7];
   assign sdaS = pinSync[6];
   assign cpuStopS = pinSync[5];
   assign pciStopS = pinSync[4];

   // ==========================================================
   // Straps
   // ==========================================================
   logic strapsTaken;
   logic [1:0] strapWait;
   logic [2:0] strapCode;

   // Synchronisers still hold reset ones at first, so wait until they carry the pins
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         strapsTaken <= 1'b0;
         strapWait <= 2'h0;
         strapCode <= STRAP_CODE_RESET;
         modeStrap <= MODE_RESET;
      end else if (!strapsTaken) begin
         if (strapWait == STRAP_SETTLE) begin
            strapsTaken <= 1'b1;
            strapCode <= {pinSync[1], pinSync[2], pinSync[3]};
            modeStrap <= pinSync[0];
         end else begin
            strapWait <= strapWait + 2'h1;
         end
      end
   end

   // ==========================================================
   // Serial bus conditions
   // ==========================================================
   logic sclD;
   logic sdaD;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sclD <= 1'b1;
         sdaD <= 1'b1;
      end else begin
         sclD <= sclS;
         sdaD <= sdaS;
      end
   end

   logic startCond;
   logic stopCond;
   logic sclRise;
   logic sclFall;
   assign startCond = sclS & sclD & sdaD & ~sdaS;
   assign stopCond = sclS & sclD & ~sdaD & sdaS;
   assign sclRise = sclS & ~sclD;
   assign sclFall = ~sclS & sclD;

   // ==========================================================
   // Serial slave
   // ==========================================================
   serial_state_t state;
   logic [7:0] rxShift;
   logic [7:0] txShift;
   logic [3:0] bitCnt;
   logic [3:0] byteIdx;
   logic readMode;
   logic masterNack;
   logic [7:0] shadowCtrl;
   logic [7:0] activeCtrl;
   logic ctrlDirty;
   logic [3:0] nextIdx;
   logic [7:0] readNow;
   logic [7:0] readNext;

   // Only byte zero is held here; higher bytes read back as constant
   function automatic logic [7:0] regByte(input logic [3:0] idx, input logic [7:0] r0);
      regByte = (idx == 4'h0) ? r0 : UNIMPL_READ;
   endfunction : regByte

   assign nextIdx = (byteIdx == IDX_MAX) ? byteIdx : byteIdx + 4'h1;
   assign readNow = regByte(byteIdx, shadowCtrl);
   assign readNext = regByte(nextIdx, shadowCtrl);
   assign serialDataOut = 1'b0;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= S_IDLE;
         bitCnt <= 4'h0;
         byteIdx <= 4'h0;
         rxShift <= 8'h00;
         txShift <= 8'h00;
         readMode <= 1'b0;
         masterNack <= 1'b0;
         serialDataOe <= 1'b0;
      end else if (startCond) begin
         state <= S_ADDR;
         bitCnt <= 4'h0;
         byteIdx <= 4'h0;
         serialDataOe <= 1'b0;
      end else if (stopCond) begin
         state <= S_IDLE;
         serialDataOe <= 1'b0;
      end else begin
         case (state)
            S_IDLE: begin
               serialDataOe <= 1'b0;
            end
            S_ADDR: begin
               if (sclRise) begin
                  rxShift <= {rxShift[6:0], sdaS};
                  bitCnt <= bitCnt + 4'h1;
               end else if (sclFall && bitCnt == BITS_PER_BYTE) begin
                  bitCnt <= 4'h0;
                  if (rxShift[7:1] == SLAVE_ADDR) begin
                     serialDataOe <= 1'b1;
                     readMode <= rxShift[0];
                     state <= S_ADDR_ACK;
                  end else begin
                     state <= S_IDLE;
                  end
               end
            end
            S_ADDR_ACK: begin
               if (sclFall) begin
                  if (readMode) begin
                     // Read starts at byte zero with no header
                     serialDataOe <= ~readNow[7];
                     txShift <= {readNow[6:0], 1'b0};
                     bitCnt <= 4'h1;
                     state <= S_READ;
                  end else begin
                     serialDataOe <= 1'b0;
                     state <= S_WRITE;
                  end
               end
            end
            S_WRITE: begin
               if (sclRise) begin
                  rxShift <= {rxShift[6:0], sdaS};
                  bitCnt <= bitCnt + 4'h1;
               end else if (sclFall && bitCnt == BITS_PER_BYTE) begin
                  bitCnt <= 4'h0;
                  serialDataOe <= 1'b1;
                  byteIdx <= nextIdx;
                  state <= S_WRITE_ACK;
               end
            end
            S_WRITE_ACK: begin
               if (sclFall) begin
                  serialDataOe <= 1'b0;
                  state <= S_WRITE;
               end
            end
            S_READ: begin
               if (sclRise && bitCnt == 4'h0) begin
                  masterNack <= sdaS;
               end else if (sclFall) begin
                  if (bitCnt == BITS_PER_BYTE) begin
                     serialDataOe <= 1'b0;
                     bitCnt <= 4'h0;
                  end else if (bitCnt == 4'h0) begin
                     if (masterNack) begin
                        state <= S_IDLE;
                     end else begin
                        serialDataOe <= ~readNext[7];
                        txShift <= {readNext[6:0], 1'b0};
                        byteIdx <= nextIdx;
                        bitCnt <= 4'h1;
                     end
                  end else begin
                     serialDataOe <= ~txShift[7];
                     txShift <= {txShift[6:0], 1'b0};
                     bitCnt <= bitCnt + 4'h1;
                  end
               end
            end
            default: begin
               state <= S_IDLE;
               serialDataOe <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // Control byte
   // ==========================================================
   logic writeByteDone;
   assign writeByteDone = (state == S_WRITE) && !startCond && !stopCond
                          && sclFall && bitCnt == BITS_PER_BYTE;

   // Shadow holds what was written; readback shows the shadow
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         shadowCtrl <= CTRL_RESET;
      end else if (writeByteDone && byteIdx == HEADER_BYTES) begin
         shadowCtrl <= rxShift;
      end
   end

   // Applied only at stop so a half-written transfer changes nothing
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         activeCtrl <= CTRL_RESET;
         ctrlDirty <= 1'b0;
      end else if (writeByteDone && byteIdx == HEADER_BYTES) begin
         ctrlDirty <= 1'b1;
      end else if (stopCond && ctrlDirty) begin
         activeCtrl <= shadowCtrl;
         ctrlDirty <= 1'b0;
      end
   end

   assign freqCode = activeCtrl[BIT_SOFT_SELECT] ?
                     activeCtrl[BIT_CODE_HI:BIT_CODE_LO] : strapCode;
   assign spreadNarrow = activeCtrl[BIT_SPREAD_NARROW];
   assign spreadDown = activeCtrl[BIT_SPREAD_DOWN];
   assign spreadEnable = activeCtrl[BIT_SPREAD_ENABLE];
   assign clkOutEnable = ~activeCtrl[BIT_TRISTATE];

   // ==========================================================
   // Stop gating
   // ==========================================================
   logic runCpu;
   logic runPci;

   // Stop inputs count only in mode 0; no per-output serial enables here
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         runCpu <= 1'b1;
         runPci <= 1'b1;
      end else begin
         runCpu <= modeStrap | cpuStopS;
         runPci <= modeStrap | pciStopS;
      end
   end

   clock_stop_gate cpuGate (
      .refClk(freeBusClk),
      .rst(rst),
      .gateClk(cpuClkRaw),
      .runRequest(runCpu),
      .clkOut(cpuClkOut)
   );

   clock_stop_gate pciGate (
      .refClk(freeBusClk),
      .rst(rst),
      .gateClk(freeBusClk),
      .runRequest(runPci),
      .clkOut(pciClkOut)
   );

   // ==========================================================
   // Dual-purpose pins
   // ==========================================================
   logic pinDrive;
   assign pinDrive = strapsTaken & clkOutEnable;

   assign strap0PinOut = clk48Raw;
   assign strap1PinOut = freeBusClk;
   assign strap2PinOut = pciClkOut;
   assign modePinOut = clk24Raw;
   assign strap0PinOe = pinDrive;
   assign strap1PinOe = pinDrive;
   assign strap2PinOe = pinDrive;
   assign modePinOe = pinDrive;
   assign cpuStopOut = sdramClkRaw;
   assign pciStopOut = sdramClkRaw;
   assign cpuStopOe = pinDrive & modeStrap;
   assign pciStopOe = pinDrive & modeStrap;
endmodule : clock_serial_control
`default_nettype wire

//--- hdl/clock_stop_gate.sv
/*
 Glitch-free stop gate for one clock group.
 Assumes the gated clock is frequency-locked to the free-running bus clock.
*/
`default_nettype none
module clock_stop_gate (
   input wire logic refClk, // Free-running bus clock
   input wire logic rst, // Power-up reset, active high
   input wire logic gateClk, // Clock to be gated
   input wire logic runRequest, // Level from system domain, 1 = run
   output logic clkOut // Gated clock
);
   logic runMeta;
   logic runSync;
   logic enable;

   // Request seen on a rising edge of the free-running clock first
   always_ff @(posedge refClk or posedge rst) begin
      if (rst) begin
         runMeta <= 1'b1;
         runSync <= 1'b1;
      end else begin
         runMeta <= runRequest;
         runSync <= runMeta;
      end
   end

   // Enable changes only while the clock is low, so no runt high phase
   always_ff @(negedge gateClk or posedge rst) begin
      if (rst) enable <= 1'b1;
      else enable <= runSync;
   end

   assign clkOut = gateClk & enable;
endmodule : clock_stop_gate
`default_nettype wire

//--- tb/clock_serial_control_assertions.sv
/*
 Pin-level checker of the serial control block.
 Assumes binding onto clock_serial_control; all checks on clock.
*/
`default_nettype none
module clock_serial_control_assertions (
   input wire logic clock, // Clock
   input wire logic rst, // Reset
   input wire logic serial_clock_pin, // Serial clock
   input wire logic serialDataIn, // Data level
   input wire logic serialDataOut, // Data drive
   input wire logic serialDataOe, // Data enable
   input wire logic cpuStopIn, // Pin level
   input wire logic pciStopIn, // Pin level
   input wire logic cpuStopOe, // Pin enable
   input wire logic pciStopOe, // Pin enable
   input wire logic strap0PinOe, // Pin enable
   input wire logic modePinOe, // Pin enable
   input wire logic cpuClkOut, // CPU clock
   input wire logic pciClkOut, // Bus clock
   input wire logic clkOutEnable, // Enable
   input wire logic [2:0] freqCode, // Code
   input wire logic spreadNarrow, // Amount
   input wire logic spreadDown, // Type
   input wire logic spreadEnable, // On
   input wire logic modeStrap // Strap
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   // ======
   // Stop gating, 8 clocks covers sync plus bus clock waits
   sequence cpuHeld;
      (!modeStrap && !cpuStopIn) [*8];
   endsequence
   sequence pciHeld;
      (!modeStrap && !pciStopIn) [*8];
   endsequence
   cpu_stop_low_a: assert property (cpuHeld |-> !cpuClkOut)
      else $error("cpu clock high while stopped");
   pci_stop_low_a: assert property (pciHeld |-> !pciClkOut)
      else $error("bus clock high while stopped");
   // ======
   // Pins and settings
   tristate_pins_a: assert property (!clkOutEnable |->
      !(strap0PinOe || modePinOe || cpuStopOe || pciStopOe))
      else $error("pin driven while tristated");
   stop_pins_in_a: assert property (!modeStrap |-> !cpuStopOe && !pciStopOe)
      else $error("stop pin driven in stop mode");
   mode_pin_out_a: assert property (modeStrap |-> cpuStopOe == strap0PinOe)
      else $error("stop pin not a clock output");
   ack_low_a: assert property (serialDataOe |-> !serialDataOut)
      else $error("data driven high");
   data_scl_low_a: assert property ($changed(serialDataOe) |-> !serial_clock_pin)
      else $error("data changed with serial clock high");
   code_at_stop_a: assert property ($changed(freqCode) |->
      serial_clock_pin && serialDataIn)
      else $error("code changed before stop");
   spread_at_stop_a: assert property
      ($changed({spreadNarrow, spreadDown, spreadEnable, clkOutEnable}) |->
      serial_clock_pin && serialDataIn)
      else $error("settings changed before stop");
endmodule : clock_serial_control_assertions
bind clock_serial_control clock_serial_control_assertions chk (.clock, .rst,
   .serial_clock_pin, .serialDataIn, .serialDataOut, .serialDataOe, .cpuStopIn,
   .pciStopIn, .cpuStopOe, .pciStopOe, .strap0PinOe, .modePinOe, .cpuClkOut,
   .pciClkOut, .clkOutEnable, .freqCode, .spreadNarrow, .spreadDown,
   .spreadEnable, .modeStrap);
`default_nettype wire

//--- tb/serial_master_model.sv
/*
 Serial bus master model for the control slave.
 Assumes the bench resolves the pulled-up data wire.
*/
`default_nettype none
module serial_master_model (
   input wire logic clock, // Bench clock
   input wire logic sdaLevel, // Data wire
   output logic sclOut, // Serial clock
   output logic sdaOe // 1 = pull data low
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sclOut = 1'b1;
      sdaOe = 1'b0;
   end
   task automatic hold();
      repeat (6) @(negedge clock);
   endtask : hold
   task automatic busStart();
      sdaOe = 1'b1;
      hold();
      sclOut = 1'b0;
      hold();
   endtask : busStart
   task automatic busStop();
      sdaOe = 1'b1;
      hold();
      sclOut = 1'b1;
      hold();
      sdaOe = 1'b0;
      hold();
   endtask : busStop
   // Data moves one clock after the fall, never with clock high
   task automatic pulse(output logic bitSeen);
      hold();
      sclOut = 1'b1;
      hold();
      bitSeen = sdaLevel;
      sclOut = 1'b0;
      @(negedge clock);
   endtask : pulse
   task automatic sendByte(input logic [7:0] b, output logic ack);
      logic unused;
      for (int i = 7; i >= 0; i--) begin
         sdaOe = !b[i];
         pulse(unused);
      end
      sdaOe = 1'b0;
      pulse(ack);
   endtask : sendByte
   task automatic recvByte(input logic last, output logic [7:0] b);
      logic unused;
      sdaOe = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         pulse(b[i]);
      end
      sdaOe = !last;
      pulse(unused);
      sdaOe = 1'b0;
   endtask : recvByte
endmodule : serial_master_model
`default_nettype wire

//--- tb/tb_top.sv
/*
 Bench of the serial control block with a bus master model.
 Assumes package, design and checker are compiled first.
*/
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import clock_ctrl_pkg::*;
   localparam logic [2:0] STRAP = 3'h5;
   localparam int SETTLE_CYCLES = 32'h124f8; // 3 ms of 40 ns cycles
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic freeBusClk = 1'b0;
   logic cpuStopN = 1'b1;
   logic pciStopN = 1'b1;
   logic [7:0] curCtrl = CTRL_RESET;
   logic sclOut, sdaOe, serialDataOut, serialDataOe, cpuClkOut, pciClkOut;
   logic cpuStopOut, cpuStopOe, pciStopOut, pciStopOe, strap0PinOut, strap0PinOe;
   logic strap1PinOut, strap1PinOe, strap2PinOut, strap2PinOe, modePinOut, modePinOe;
   logic clkOutEnable, spreadNarrow, spreadDown, spreadEnable, modeStrap;
   logic [2:0] freqCode;
   wire logic sda = !(serialDataOe | sdaOe);
   int miscompares = 0;
   int totalChecks = 0;
   always #20 clock = !clock;
   initial begin
      #7;
      forever #15 freeBusClk = !freeBusClk;
   end
   clock_serial_control dut (.clock(clock), .rst(rst), .freeBusClk(freeBusClk),
      .cpuClkRaw(freeBusClk), .sdramClkRaw(freeBusClk), .clk48Raw(freeBusClk),
      .clk24Raw(freeBusClk), .serial_clock_pin(sclOut), .serialDataIn(sda),
      .serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
      .cpuStopIn(cpuStopOe ? cpuStopOut : cpuStopN), .cpuStopOut(cpuStopOut),
      .cpuStopOe(cpuStopOe), .pciStopIn(pciStopOe ? pciStopOut : pciStopN),
      .pciStopOut(pciStopOut), .pciStopOe(pciStopOe),
      .strap0PinIn(strap0PinOe ? strap0PinOut : STRAP[0]), .strap0PinOut(strap0PinOut),
      .strap0PinOe(strap0PinOe), .strap1PinIn(strap1PinOe ? strap1PinOut : STRAP[1]),
      .strap1PinOut(strap1PinOut), .strap1PinOe(strap1PinOe),
      .strap2PinIn(strap2PinOe ? strap2PinOut : STRAP[2]), .strap2PinOut(strap2PinOut),
      .strap2PinOe(strap2PinOe), .modePinIn(modePinOe ? modePinOut : 1'b0),
      .modePinOut(modePinOut), .modePinOe(modePinOe), .cpuClkOut(cpuClkOut),
      .pciClkOut(pciClkOut), .clkOutEnable(clkOutEnable), .freqCode(freqCode),
      .spreadNarrow(spreadNarrow), .spreadDown(spreadDown),
      .spreadEnable(spreadEnable), .modeStrap(modeStrap));
   serial_master_model master (.clock(clock), .sdaLevel(sda), .sclOut(sclOut),
      .sdaOe(sdaOe));
   // ======
   // Tasks
   task automatic checkVal(input string what, input logic [7:0] expv,
      input logic [7:0] got);
      totalChecks++;
      if (got !== expv) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, expv, got);
      end
   endtask : checkVal
   task automatic summarize();
      $display("Checks %0d miscompares %0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize
   task automatic powerUp();
      rst = 1'b1;
      curCtrl = CTRL_RESET;
      repeat (3) @(negedge clock);
      rst = 1'b0;
      repeat (6) @(negedge clock);
   endtask : powerUp
   task automatic checkOutputs();
      logic [2:0] c;
      c = curCtrl[3] ? curCtrl[6:4] : STRAP;
      checkVal("freqCode", {5'h0, c}, {5'h0, freqCode});
      checkVal("spread", {5'h0, curCtrl[7], curCtrl[2:1]},
         {5'h0, spreadNarrow, spreadDown, spreadEnable});
      checkVal("outEnable", {7'h0, !curCtrl[0]}, {7'h0, clkOutEnable});
      checkVal("pin drive", {4'h0, {4{!curCtrl[0]}}}, {2'h0, cpuStopOe, pciStopOe,
         strap0PinOe, strap1PinOe, strap2PinOe, modePinOe});
   endtask : checkOutputs
   // Byte 1 is sent too: acked but has no register behind it
   task automatic writeCtrl(input logic [7:0] v);
      logic ack;
      logic [7:0] seq [5];
      seq = '{8'hd2, 8'h00, 8'h01, v, 8'h5a};
      master.busStart();
      foreach (seq[i]) begin
         master.sendByte(seq[i], ack);
         checkVal("write ack", 8'h00, {7'h0, ack});
      end
      checkOutputs();
      master.busStop();
      curCtrl = v;
      checkOutputs();
   endtask : writeCtrl
   task automatic readCtrl();
      logic ack;
      logic [7:0] b;
      master.busStart();
      master.sendByte(8'hd3, ack);
      checkVal("read ack", 8'h00, {7'h0, ack});
      master.recvByte(1'b0, b);
      checkVal("read byte0", curCtrl, b);
      master.recvByte(1'b1, b);
      checkVal("read byte1", UNIMPL_READ, b);
      master.busStop();
   endtask : readCtrl
   task automatic checkGating(input logic cpuRun, input logic pciRun);
      int cpuHigh;
      int pciHigh;
      cpuHigh = 0;
      pciHigh = 0;
      cpuStopN = cpuRun;
      pciStopN = pciRun;
      repeat (10) @(negedge clock);
      repeat (30) begin
         @(negedge clock);
         cpuHigh += int'(cpuClkOut);
         pciHigh += int'(pciClkOut);
      end
      checkVal("cpu running", {7'h0, cpuRun}, {7'h0, cpuHigh != 0});
      checkVal("pci running", {7'h0, pciRun}, {7'h0, pciHigh != 0});
   endtask : checkGating
   // ======
   // Tests
   initial begin
      #4_000_000;
      miscompares++;
      summarize();
   end
   initial begin
      logic ack;
      powerUp();
      // Oscillators settle before the master may touch any output
      repeat (SETTLE_CYCLES) @(negedge clock);
      checkOutputs();
      checkVal("modeStrap", 8'h00, {7'h0, modeStrap});
      readCtrl();
      $display("Test defaults done");
      master.busStart();
      master.sendByte(8'ha0, ack);
      checkVal("foreign addr", 8'h01, {7'h0, ack});
      master.busStop();
      writeCtrl(8'hbe);
      readCtrl();
      $display("Test write readback done");
      for (int c = 0; c < 8; c++) begin
         writeCtrl({1'b0, c[2:0], 4'h8});
      end
      writeCtrl(8'h01);
      writeCtrl(8'h00);
      $display("Test codes and tristate done");
      for (int g = 0; g < 4; g++) begin
         checkGating(g[1], g[0]);
      end
      $display("Test stop gating done");
      writeCtrl(8'h86);
      powerUp();
      checkOutputs();
      readCtrl();
      $display("Test second power-up done");
      summarize();
   end
endmodule : tb_top
`default_nettype wire
